// ---- lcf_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: included by the package and by both link ends
// Notes:   definitions only
`ifndef LCF_MAP_SVH
`define LCF_MAP_SVH

// link timing: one bit-time is one period of the link clock
`define LCF_CLK_NS     8
`define LCF_BT_NS      64
`define LCF_DIV        (`LCF_BT_NS / `LCF_CLK_NS)
`define LCF_PH_RISE    3'(`LCF_DIV - 1)
`define LCF_PH_LAUNCH  3'(`LCF_DIV / 2 - 1)
`define LCF_PH_SAMP    3'h2

// test interval and crc window, in bit-times
`define LCF_TEST_BT    10'h200
`define LCF_CRC_WIN    10'h200
`define LCF_ONES_MAX   2'h3
`define LCF_CRC_INIT   8'hFF
`define LCF_CRC_POLY   8'h07
`define LCF_FORCE_XOR  8'h01
`define LCF_LFSR_SEED  9'h1A5

// no-operation packet
`define LCF_CMD_NOP    6'h00
`define LCF_NOP_DIAG   1
`define LCF_CMD_MAX    6'h03
`define LCF_DW_MAX     6'h1F
`define LCF_BUF_MAX    6'h03
`define LCF_CRED_MAX   6'h3F

// register map, word index on the plain port
`define LCF_A_CTRL     4'h0
`define LCF_A_STAT     4'h1
`define LCF_A_CRED     4'h2
`define LCF_N_CRED     4'h6
`define LCF_C_START    0
`define LCF_C_FORCE    1
`define LCF_C_DWREQ    2
`define LCF_C_RETRY    3
`define LCF_C_FLOOD    4
`define LCF_S_ERR      0

`endif

// ---- lcf_pkg.sv ----
// Purpose: types and shared functions of the link ends
// Assumes: constants come from lcf_map.svh
// Notes:   credit index 0..2 command, 3..5 data (posted, nonposted, resp)
`include "lcf_map.svh"
package lcf_pkg;

  typedef enum logic [1:0] {
    TX_RUN  = 2'b00,
    TX_NOP  = 2'b01,
    TX_TEST = 2'b10
  } lcf_tx_e;

  typedef enum logic [1:0] {
    RX_CMD  = 2'b00,
    RX_NOP1 = 2'b01,
    RX_NOP2 = 2'b10,
    RX_NOP3 = 2'b11
  } lcf_rx_e;

  typedef logic [5:0][4:0] lcf_grant_t;
  typedef logic [5:0]      lcf_cnt_t;

  // serial crc-8 over control line and data lines of one bit-time
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [8:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 8; i >= 0; i--) begin
      r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ `LCF_CRC_POLY)
                        : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc8

  // saturating credit add, excess increments are dropped
  function automatic lcf_cnt_t sat_add(input lcf_cnt_t c,
                                       input logic [4:0] inc);
    logic [6:0] s;
    s = {1'b0, c} + {2'h0, inc};
    return s[6] ? `LCF_CRED_MAX : s[5:0];
  endfunction : sat_add

  // one bit-time of a no-operation packet
  function automatic logic [7:0] nop_byte(input logic [1:0] idx,
                                          input lcf_grant_t g,
                                          input logic diag);
    logic [7:0] b;
    b = {2'h0, `LCF_CMD_NOP};
    unique case (idx)
      2'h0: b = {2'h0, `LCF_CMD_NOP};
      2'h1: b = {g[5][4:3], g[2][1:0], g[3][4:3], g[0][1:0]};
      2'h2: b = {1'b0, g[5][2], g[4][4:3], g[1][1:0], diag, 1'b0};
      2'h3: b = {g[5][1:0], g[3][2:0], g[4][2:0]};
    endcase
    return b;
  endfunction : nop_byte

endpackage : lcf_pkg

// ---- lcf_link_if.sv ----
// Purpose: one byte lane forward, credit lane back, shared link clock
// Assumes: the transmitting end makes the link clock
// Notes:   reverse lane carries only no-operation packets
interface lcf_link_if;
  logic       link_clk;
  logic [7:0] data_lines;
  logic       control_line;
  logic [7:0] rev_data_lines;
  logic       rev_control_line;

  modport tx_end (
    output link_clk,
    output data_lines,
    output control_line,
    input  rev_data_lines,
    input  rev_control_line
  );

  modport rx_end (
    input  link_clk,
    input  data_lines,
    input  control_line,
    output rev_data_lines,
    output rev_control_line
  );
endinterface : lcf_link_if

// ---- lcf_link_tx.sv ----
// Purpose: transmitting end: crc test source and data credit counters
// Assumes: link clock made here by a divider; reverse lane returns NOPs
// Notes:   credits count units: packets, 64-byte buffers or doublewords
// Contract
// - writing one to start bit starts test
// - diag NO_OPERATION_PACKET opens 512 ignored bit-times
// - pattern never has four all-ones bit-times
// - crc keeps running; receiver drops test data
// - receiver parser frozen through the test
// - receiver logs crc errors, fatal with flood
// - force bit corrupts test crc per lane
// - start bit self-clears after covering crc stuffed
// - user stream resumes exactly where it paused
// - software checks both partners support the test
// - 64-byte granular flow control always supported
// - cold reset selects 64-byte mode
// - mode changes only at warm reset
// - command credits stay per packet
// - data credit fields widen to five bits
// - NO_OPERATION_PACKET bit-times one to three carry fields
// - byte-mask doubleword counts as data
// - credit counters saturate, never wrap
// - credit counters are six bits wide
// - doubleword mode barred with link retry
`include "lcf_map.svh"
module lcf_link_tx
  import lcf_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        cold_rst_i,
  input  wire logic        link_stop_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        tx_valid_i,
  input  wire logic        tx_ctl_i,
  input  wire logic [7:0]  tx_byte_i,
  output logic             tx_ready_o,
  input  wire logic [5:0]  take_i,
  lcf_link_if.tx_end       lnk
);

  logic        rst;
  logic [2:0]  cnt_ff;
  logic        ls1_ff;
  logic        ls2_ff;
  logic        lclk_ff;
  logic [7:0]  data_ff;
  logic        ctl_ff;
  logic        launch;
  logic        samp;
  logic [8:0]  rs1_ff;
  logic [8:0]  rs2_ff;
  logic [1:0]  ridx_ff;
  logic [7:0]  rb1_ff;
  logic [7:0]  rb2_ff;
  logic        rdone;
  lcf_grant_t  g;
  lcf_cnt_t    cred_ff [6];
  lcf_cnt_t    nxt_cred [6];
  lcf_tx_e     state_ff;
  logic [1:0]  nidx_ff;
  logic        diag_ff;
  logic [9:0]  tcnt_ff;
  logic [9:0]  win_ff;
  logic [7:0]  crc_ff;
  logic [8:0]  lfsr_ff;
  logic [1:0]  ones_ff;
  logic        pend_ff;
  logic        arm_ff;
  logic        ready_ff;
  logic        start_ff;
  logic        force_ff;
  logic        dwreq_ff;
  logic        retry_ff;
  logic        dw_mode_ff;
  logic [31:0] rdata_ff;
  logic        stuff;
  logic        start_go;
  logic        user_go;
  logic        corrupt;
  logic [8:0]  pat;
  logic [8:0]  out9;

  assign rst                  = srst_i | cold_rst_i;
  assign lnk.link_clk         = lclk_ff;
  assign lnk.data_lines       = data_ff;
  assign lnk.control_line     = ctl_ff;
  assign tx_ready_o           = ready_ff;
  assign reg_rdata_o          = rdata_ff;

  // link clock divider; a link stop freezes it, state is kept
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      cnt_ff <= 3'h0;
    end else if (!ls2_ff) begin
      cnt_ff <= (cnt_ff == `LCF_PH_RISE) ? 3'h0 : cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      lclk_ff <= 1'b1;                      // first edge out is a launch
    end else if (!ls2_ff && cnt_ff == `LCF_PH_RISE) begin
      lclk_ff <= 1'b1;
    end else if (launch) begin
      lclk_ff <= 1'b0;
    end
  end

  assign launch = !ls2_ff && (cnt_ff == `LCF_PH_LAUNCH);
  assign samp   = !ls2_ff && (cnt_ff == `LCF_PH_SAMP);

  // reverse lane and link stop synchronisers
  always_ff @(posedge ref_clk_i) begin
    rs1_ff <= {lnk.rev_control_line, lnk.rev_data_lines};
    rs2_ff <= rs1_ff;
    ls1_ff <= link_stop_i;
    ls2_ff <= ls1_ff;
  end

  // reverse NO_OPERATION_PACKET framing: control line marks bit-time 0
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      ridx_ff <= 2'h0;
      rb1_ff  <= 8'h00;
      rb2_ff  <= 8'h00;
    end else if (samp) begin
      if (rs2_ff[8]) begin
        ridx_ff <= 2'h1;
      end else if (ridx_ff == 2'h1) begin
        rb1_ff  <= rs2_ff[7:0];
        ridx_ff <= 2'h2;
      end else if (ridx_ff == 2'h2) begin
        rb2_ff  <= rs2_ff[7:0];
        ridx_ff <= 2'h3;
      end else begin
        ridx_ff <= 2'h0;
      end
    end
  end

  assign rdone = samp && !rs2_ff[8] && (ridx_ff == 2'h3);

  // released units per channel from the received NO_OPERATION_PACKET
  always_comb begin
    g[0] = {3'h0, rb1_ff[1:0]};
    g[1] = {3'h0, rb2_ff[3:2]};
    g[2] = {3'h0, rb1_ff[5:4]};
    g[3] = {rb1_ff[3:2], rs2_ff[5:3]};
    g[4] = {rb2_ff[5:4], rs2_ff[2:0]};
    g[5] = {rb1_ff[7:6], rb2_ff[6], rs2_ff[7:6]};
    for (int i = 3; i < 6; i++) begin
      if (!dw_mode_ff) begin
        g[i] = {3'h0, g[i][4:3]};
      end
    end
  end

  // credit counters; take_i counts mask doubleword as data
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      nxt_cred[i] = cred_ff[i];
      if (take_i[i] && cred_ff[i] != 6'h00) begin
        nxt_cred[i] = cred_ff[i] - 6'h01;
      end
      if (rdone) begin
        nxt_cred[i] = sat_add(nxt_cred[i], g[i]);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < 6; i++) begin
      cred_ff[i] <= rst ? 6'h00 : nxt_cred[i];
    end
  end

  // byte chosen for the next bit-time
  always_comb begin
    stuff    = (win_ff == `LCF_CRC_WIN);
    start_go = start_ff && !pend_ff;
    user_go  = (state_ff == TX_RUN) && !start_go && tx_valid_i;
    corrupt  = arm_ff && (state_ff == TX_TEST || pend_ff);
    pat      = lfsr_ff;
    if (ones_ff == `LCF_ONES_MAX && &lfsr_ff) begin
      pat[0] = 1'b0;
    end
    out9 = {1'b1, nop_byte(2'h0, '0, 1'b0)};
    if (stuff) begin
      out9 = {1'b0, crc_ff ^ (corrupt ? `LCF_FORCE_XOR : 8'h00)};
    end else begin
      unique case (state_ff)
        TX_RUN: begin
          if (user_go) begin
            out9 = {tx_ctl_i, tx_byte_i};
          end
        end
        TX_NOP:  out9 = {1'b1, nop_byte(nidx_ff, '0, diag_ff)};
        TX_TEST: out9 = pat;
        default: out9 = {1'b1, nop_byte(2'h0, '0, 1'b0)};
      endcase
    end
  end

  // drive the lane at the falling link clock
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      data_ff  <= 8'h00;
      ctl_ff   <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= launch && !stuff && user_go;
      if (launch) begin
        data_ff <= out9[7:0];
        ctl_ff  <= out9[8];
      end
    end
  end

  // crc window and stuffing run through the test as well
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      win_ff <= 10'h000;
      crc_ff <= `LCF_CRC_INIT;
    end else if (launch) begin
      win_ff <= stuff ? 10'h000 : win_ff + 10'h001;
      crc_ff <= stuff ? `LCF_CRC_INIT : crc8(crc_ff, out9);
    end
  end

  // sequencer: user bytes, NOPs, diagnostic pattern
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      state_ff <= TX_RUN;
      nidx_ff  <= 2'h0;
      diag_ff  <= 1'b0;
      tcnt_ff  <= 10'h000;
      lfsr_ff  <= `LCF_LFSR_SEED;
      ones_ff  <= 2'h0;
    end else if (launch) begin
      if (stuff) begin
        ones_ff <= 2'h0;
      end else begin
        unique case (state_ff)
          TX_RUN: begin
            if (!user_go) begin
              state_ff <= TX_NOP;
              nidx_ff  <= 2'h1;
              diag_ff  <= start_go;
            end
          end
          TX_NOP: begin
            nidx_ff <= nidx_ff + 2'h1;
            if (nidx_ff == 2'h3) begin
              state_ff <= diag_ff ? TX_TEST : TX_RUN;
              tcnt_ff  <= 10'h000;
            end
          end
          TX_TEST: begin
            lfsr_ff  <= {lfsr_ff[7:0], lfsr_ff[8] ^ lfsr_ff[4]};
            ones_ff  <= (&pat) ? ones_ff + 2'h1 : 2'h0;
            tcnt_ff  <= tcnt_ff + 10'h001;
            if (tcnt_ff == `LCF_TEST_BT - 10'h001) begin
              state_ff <= TX_RUN;
            end
          end
          default: state_ff <= TX_RUN;
        endcase
      end
    end
  end

  // end of test waits for the crc slot that covers its tail
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      pend_ff <= 1'b0;
      arm_ff  <= 1'b0;
    end else if (launch) begin
      if (stuff) begin
        pend_ff <= 1'b0;
        if (corrupt) begin
          arm_ff <= 1'b0;
        end
      end else if (state_ff == TX_TEST &&
                   tcnt_ff == `LCF_TEST_BT - 10'h001) begin
        pend_ff <= 1'b1;
      end else if (state_ff == TX_RUN && !user_go && start_go) begin
        arm_ff <= force_ff;
      end
    end
  end

  // start bit: software set wins over hardware clear
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      start_ff <= 1'b0;
      force_ff <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `LCF_A_CTRL) begin
        force_ff <= reg_wdata_i[`LCF_C_FORCE];
      end
      if (reg_wr_i && reg_addr_i == `LCF_A_CTRL &&
          reg_wdata_i[`LCF_C_START]) begin
        start_ff <= 1'b1;
      end else if (launch && stuff && pend_ff) begin
        start_ff <= 1'b0;
      end
    end
  end

  // mode request survives warm reset, lost only at cold reset
  always_ff @(posedge ref_clk_i) begin
    if (cold_rst_i) begin
      dwreq_ff <= 1'b0;
      retry_ff <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `LCF_A_CTRL) begin
      dwreq_ff <= reg_wdata_i[`LCF_C_DWREQ];
      retry_ff <= reg_wdata_i[`LCF_C_RETRY];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (cold_rst_i) begin
      dw_mode_ff <= 1'b0;
    end else if (srst_i) begin
      dw_mode_ff <= dwreq_ff && !retry_ff;
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      rdata_ff <= 32'h0000_0000;
      if (reg_addr_i == `LCF_A_CTRL) begin
        rdata_ff[3:0] <= {retry_ff, dwreq_ff, force_ff, start_ff};
      end else if (reg_addr_i == `LCF_A_STAT) begin
        rdata_ff[4:0] <= {dw_mode_ff, pend_ff, arm_ff, state_ff};
      end else if (reg_addr_i >= `LCF_A_CRED &&
                   reg_addr_i < `LCF_A_CRED + `LCF_N_CRED) begin
        rdata_ff[5:0] <= cred_ff[3'(reg_addr_i - `LCF_A_CRED)];
      end
    end
  end

endmodule : lcf_link_tx

// ---- lcf_link_rx.sv ----
// Purpose: receiving end: crc check, test gating, credit release NOPs
// Assumes: link clock and lanes sampled through two flip-flops
// Notes:   reverse lane updated three ref clocks after a link clock rise
`include "lcf_map.svh"
module lcf_link_rx
  import lcf_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        cold_rst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [5:0]  free_i,
  output logic             rx_valid_o,
  output logic             rx_ctl_o,
  output logic      [7:0]  rx_byte_o,
  output logic             fatal_o,
  lcf_link_if.rx_end       lnk
);

  logic        rst;
  logic        c1_ff;
  logic        c2_ff;
  logic        cp_ff;
  logic [8:0]  d1_ff;
  logic [8:0]  d2_ff;
  logic        edge_s;
  logic        stuff;
  logic        bad;
  logic [9:0]  win_ff;
  logic [7:0]  crc_ff;
  logic        test_ff;
  logic [9:0]  tcnt_ff;
  lcf_rx_e     pst_ff;
  logic        diag_ff;
  logic        valid_ff;
  logic        ctl_ff;
  logic [7:0]  byte_ff;
  logic        err_ff;
  logic        fatal_ff;
  logic        flood_ff;
  logic        dwreq_ff;
  logic        retry_ff;
  logic        dw_mode_ff;
  logic [1:0]  vidx_ff;
  lcf_grant_t  sent_ff;
  lcf_grant_t  grant;
  lcf_cnt_t    pend_ff [6];
  logic [7:0]  rvd_ff;
  logic        rvc_ff;
  logic [31:0] rdata_ff;
  logic [5:0]  lim;

  assign rst                  = srst_i | cold_rst_i;
  assign lnk.rev_data_lines   = rvd_ff;
  assign lnk.rev_control_line = rvc_ff;
  assign rx_valid_o           = valid_ff;
  assign rx_ctl_o             = ctl_ff;
  assign rx_byte_o            = byte_ff;
  assign fatal_o              = fatal_ff;
  assign reg_rdata_o          = rdata_ff;

  // synchronisers; edge found on the second stage only
  always_ff @(posedge ref_clk_i) begin
    c1_ff <= lnk.link_clk;
    c2_ff <= c1_ff;
    cp_ff <= c2_ff;
    d1_ff <= {lnk.control_line, lnk.data_lines};
    d2_ff <= d1_ff;
  end

  assign edge_s = c2_ff && !cp_ff;
  assign stuff  = (win_ff == `LCF_CRC_WIN);
  assign bad    = edge_s && stuff && (d2_ff[7:0] != crc_ff);

  // crc check continues through the test interval
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      win_ff <= 10'h000;
      crc_ff <= `LCF_CRC_INIT;
    end else if (edge_s) begin
      win_ff <= stuff ? 10'h000 : win_ff + 10'h001;
      crc_ff <= stuff ? `LCF_CRC_INIT : crc8(crc_ff, d2_ff);
    end
  end

  // error log: a new error wins over a write-one clear
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      err_ff   <= 1'b0;
      fatal_ff <= 1'b0;
    end else begin
      if (bad) begin
        err_ff <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `LCF_A_STAT &&
                   reg_wdata_i[`LCF_S_ERR]) begin
        err_ff <= 1'b0;
      end
      if (bad && flood_ff) begin
        fatal_ff <= 1'b1;
      end
    end
  end

  // parser; holds still while the test runs
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      pst_ff   <= RX_CMD;
      diag_ff  <= 1'b0;
      test_ff  <= 1'b0;
      tcnt_ff  <= 10'h000;
      valid_ff <= 1'b0;
      ctl_ff   <= 1'b0;
      byte_ff  <= 8'h00;
    end else begin
      valid_ff <= 1'b0;
      if (edge_s && !stuff) begin
        if (test_ff) begin
          tcnt_ff <= tcnt_ff + 10'h001;
          if (tcnt_ff == `LCF_TEST_BT - 10'h001) begin
            test_ff <= 1'b0;
          end
        end else begin
          unique case (pst_ff)
            RX_CMD: begin
              if (d2_ff[8] && d2_ff[5:0] == `LCF_CMD_NOP) begin
                pst_ff <= RX_NOP1;
              end else begin
                valid_ff <= 1'b1;
                ctl_ff   <= d2_ff[8];
                byte_ff  <= d2_ff[7:0];
              end
            end
            RX_NOP1: pst_ff <= RX_NOP2;
            RX_NOP2: begin
              diag_ff <= d2_ff[`LCF_NOP_DIAG];
              pst_ff  <= RX_NOP3;
            end
            RX_NOP3: begin
              pst_ff  <= RX_CMD;
              test_ff <= diag_ff;
              tcnt_ff <= 10'h000;
            end
          endcase
        end
      end
    end
  end

  // release per NO_OPERATION_PACKET: commands per packet, data in units of the mode
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      lim = (i < 3) ? `LCF_CMD_MAX
                    : (dw_mode_ff ? `LCF_DW_MAX : `LCF_BUF_MAX);
      grant[i] = (pend_ff[i] > lim) ? lim[4:0] : pend_ff[i][4:0];
      if (i >= 3 && !dw_mode_ff) begin
        grant[i] = {grant[i][1:0], 3'h0};
      end
    end
  end

  // pending releases; free_i includes the byte-mask doubleword
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < 6; i++) begin
      if (rst) begin
        pend_ff[i] <= 6'h00;
      end else if (edge_s && vidx_ff == 2'h0) begin
        pend_ff[i] <= sat_add(pend_ff[i] - (i < 3 || dw_mode_ff
                       ? 6'(grant[i]) : 6'(grant[i][4:3])),
                       {4'h0, free_i[i]});
      end else begin
        pend_ff[i] <= sat_add(pend_ff[i], {4'h0, free_i[i]});
      end
    end
  end

  // reverse lane: endless NOPs carrying the releases
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      vidx_ff <= 2'h0;
      sent_ff <= '0;
      rvd_ff  <= 8'h00;
      rvc_ff  <= 1'b0;
    end else if (edge_s) begin
      vidx_ff <= vidx_ff + 2'h1;
      rvc_ff  <= (vidx_ff == 2'h0);
      if (vidx_ff == 2'h0) begin
        sent_ff <= grant;
      end
      rvd_ff  <= nop_byte(vidx_ff, sent_ff, 1'b0);
    end
  end

  // configuration; mode taken only at warm reset
  always_ff @(posedge ref_clk_i) begin
    if (cold_rst_i) begin
      dwreq_ff <= 1'b0;
      retry_ff <= 1'b0;
      flood_ff <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `LCF_A_CTRL) begin
      dwreq_ff <= reg_wdata_i[`LCF_C_DWREQ];
      retry_ff <= reg_wdata_i[`LCF_C_RETRY];
      flood_ff <= reg_wdata_i[`LCF_C_FLOOD];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (cold_rst_i) begin
      dw_mode_ff <= 1'b0;
    end else if (srst_i) begin
      dw_mode_ff <= dwreq_ff && !retry_ff;
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      rdata_ff <= 32'h0000_0000;
      if (reg_addr_i == `LCF_A_CTRL) begin
        rdata_ff[4:2] <= {flood_ff, retry_ff, dwreq_ff};
      end else if (reg_addr_i == `LCF_A_STAT) begin
        rdata_ff[3:0] <= {dw_mode_ff, test_ff, fatal_ff, err_ff};
      end
    end
  end

endmodule : lcf_link_rx

// ---- lcf_link_chk.sv ----
// Purpose: wire checks between the two link ends
// Assumes: one ref clock; link stop held low
// Notes:   lanes judged on ref clock samples
module lcf_link_chk (
  input wire logic       ref_clk_i,
  input wire logic       srst_i,
  input wire logic       cold_rst_i,
  input wire logic       link_clk,
  input wire logic [7:0] data_lines,
  input wire logic       control_line,
  input wire logic [7:0] rev_data_lines,
  input wire logic       rev_control_line
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i || cold_rst_i);
  logic [2:0] ones_ff;
  // run of all-ones bit-times seen at link clock rise
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || cold_rst_i) ones_ff <= 3'h0;
    else if ($rose(link_clk))
      ones_ff <= &{control_line, data_lines} ? ones_ff + 3'h1 : 3'h0;
  end
  sequence rev_head_s; rev_control_line [*8]; endsequence
  sequence rev_tail_s;
    !rev_control_line [*8] ##1 !rev_control_line [*8];
  endsequence
  chk_clk_high: assert property ($rose(link_clk) |-> link_clk [*4]
    ##1 !link_clk) else $error("link clock high phase wrong");
  chk_clk_low: assert property ($fell(link_clk) |-> !link_clk [*4]
    ##1 link_clk) else $error("link clock low phase wrong");
  chk_fwd_launch: assert property ($changed({control_line,
    data_lines}) |-> $fell(link_clk)) else $error("lane moved off launch");
  chk_fwd_hold: assert property ($fell(link_clk) |=>
    $stable({control_line, data_lines}) [*7]) else $error("lane not held");
  chk_no_sync: assert property (ones_ff < 3'h4)
    else $error("four all-ones bit-times");
  chk_rev_nop: assert property ($rose(rev_control_line) |->
    rev_head_s ##1 rev_tail_s) else $error("reverse frame shape wrong");
  chk_rev_head: assert property ($rose(rev_control_line) |->
    rev_data_lines == 8'h00) else $error("reverse first bit-time not zero");
  chk_rev_hold: assert property ($changed({rev_control_line,
    rev_data_lines}) |=> $stable(rev_data_lines) [*7])
    else $error("reverse lane not held");
endmodule : lcf_link_chk

// ---- tb_link_crc_test_and_dword_flow_ctrl.sv ----
// Purpose: bench for both link ends joined by the link interface
// Assumes: both ends share clock and resets
// Notes:   link stop held low throughout
module tb_link_crc_test_and_dword_flow_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, srst = 1'b1, cold = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, t_rdata, r_rdata;
  logic        twr = 1'b0, trd = 1'b0, rwr = 1'b0, rrd = 1'b0;
  logic        tx_valid = 1'b0, tx_ready, rx_valid, rx_ctl, fatal;
  logic [7:0]  rx_byte;
  logic [5:0]  take = 6'h00, free = 6'h00;
  int          error_cnt = 0, tests_run = 0, rx_n = 0;
  lcf_link_if lnk ();
  always #4 clk = ~clk;
  lcf_link_tx lcf_link_tx_i (.ref_clk_i(clk), .srst_i(srst),
    .cold_rst_i(cold), .link_stop_i(1'b0), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(twr), .reg_rd_i(trd),
    .reg_rdata_o(t_rdata), .tx_valid_i(tx_valid), .tx_ctl_i(1'b0),
    .tx_byte_i(8'h5A), .tx_ready_o(tx_ready), .take_i(take), .lnk(lnk));
  lcf_link_rx lcf_link_rx_i (.ref_clk_i(clk), .srst_i(srst),
    .cold_rst_i(cold), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(r_rdata), .free_i(free),
    .rx_valid_o(rx_valid), .rx_ctl_o(rx_ctl), .rx_byte_o(rx_byte),
    .fatal_o(fatal), .lnk(lnk));
  lcf_link_chk lcf_link_chk_i (.ref_clk_i(clk), .srst_i(srst),
    .cold_rst_i(cold), .link_clk(lnk.link_clk),
    .data_lines(lnk.data_lines), .control_line(lnk.control_line),
    .rev_data_lines(lnk.rev_data_lines),
    .rev_control_line(lnk.rev_control_line));
  // count delivered bytes, drop the offer once taken
  always @(posedge clk) begin
    if (rx_valid) rx_n <= rx_n + 1;
    if (tx_ready) tx_valid <= 1'b0;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic r, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) {addr, wdata, rwr, twr} <= {a, d, r, !r};
    @(posedge clk) {rwr, twr} <= 2'b00;
  endtask : wr
  task automatic rdv(input logic r, input logic [3:0] a,
                     output logic [31:0] d);
    @(posedge clk) {addr, rrd, trd} <= {a, r, !r};
    @(posedge clk) {rrd, trd} <= 2'b00;
    #1 d = r ? r_rdata : t_rdata;
  endtask : rdv
  task automatic rdc(input logic r, input logic [3:0] a,
                     input logic [31:0] m, e, input string n);
    logic [31:0] d;
    rdv(r, a, d);
    chk(n, e, d & m);
  endtask : rdc
  task automatic rst(input logic w);
    @(posedge clk) {srst, cold} <= {w, !w};
    repeat (4) @(posedge clk);
    {srst, cold} <= 2'b00;
    repeat (4) @(posedge clk);
  endtask : rst
  task automatic done();
    logic [31:0] d;
    int n;
    d = 32'h1;
    for (n = 0; n < 6000 && d[0] !== 1'b0; n++) rdv(0, 4'h0, d);
    chk("start bit", 32'h0, {31'h0, d[0]});
  endtask : done
  task automatic t_cold();
    rdc(0, 4'h1, 32'h10, 32'h0, "tx mode");
    rdc(1, 4'h1, 32'h8, 32'h0, "rx mode");
    rdc(1, 4'hF, 32'hFFFFFFFF, 32'h0, "hole");
  endtask : t_cold
  task automatic t_cred();
    repeat (2) begin
      @(posedge clk) free <= 6'h09;
      repeat (39) @(posedge clk) free <= 6'h08;
      @(posedge clk) free <= 6'h00;
      repeat (1500) @(posedge clk);
    end
    rdc(0, 4'h5, 32'hFF, 32'h3F, "pd cred");
    rdc(0, 4'h2, 32'hFF, 32'h02, "pc cred");
    @(posedge clk) take <= 6'h08;
    @(posedge clk) take <= 6'h00;
    rdc(0, 4'h5, 32'hFF, 32'h3E, "pd take");
  endtask : t_cred
  task automatic t_mode();
    wr(0, 4'h0, 32'h4);
    wr(1, 4'h0, 32'h4);
    rdc(0, 4'h1, 32'h10, 32'h0, "tx mode");
    rst(1);
    rdc(0, 4'h1, 32'h10, 32'h10, "tx mode");
    rdc(1, 4'h1, 32'h8, 32'h8, "rx mode");
    repeat (20) @(posedge clk) free <= 6'h20;
    @(posedge clk) free <= 6'h00;
    repeat (1500) @(posedge clk);
    rdc(0, 4'h7, 32'hFF, 32'h14, "rd cred");
    wr(0, 4'h0, 32'hC);
    rst(1);
    rdc(0, 4'h1, 32'h10, 32'h0, "tx mode");
    wr(0, 4'h0, 32'h4);
    rst(0);
    rdc(0, 4'h0, 32'h4, 32'h0, "mode req");
    rdc(0, 4'h1, 32'h10, 32'h0, "tx mode");
  endtask : t_mode
  task automatic t_crc();
    wr(1, 4'h0, 32'h10);
    rx_n = 0;
    wr(0, 4'h0, 32'h1);
    tx_valid <= 1'b1;
    rdc(0, 4'h0, 32'h1, 32'h1, "start bit");
    repeat (200) @(posedge clk);
    rdc(1, 4'h1, 32'h4, 32'h4, "rx test");
    done();
    repeat (300) @(posedge clk);
    chk("rx count", 32'h1, rx_n);
    chk("rx byte", 32'h5A, {24'h0, rx_byte});
    chk("rx ctl", 32'h0, {31'h0, rx_ctl});
    rdc(1, 4'h1, 32'h3, 32'h0, "rx err");
    wr(0, 4'h0, 32'h2);
    wr(0, 4'h0, 32'h3);
    done();
    repeat (300) @(posedge clk);
    rdc(1, 4'h1, 32'h3, 32'h3, "rx err");
    chk("fatal", 32'h1, {31'h0, fatal});
  endtask : t_crc
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    {srst, cold} <= 2'b00;
    repeat (4) @(posedge clk);
    t_cold();
    t_cred();
    t_mode();
    t_crc();
    end_of_test();
  end
endmodule : tb_link_crc_test_and_dword_flow_ctrl
